// >>> logic/lif_pkg.sv
// Purpose: Shared constants and types for the loop interface frame/status register bank
// Assumes: 40 MHz single clock, byte-wide host register port
// Notes:   Offsets, flag bit positions and cycle counts live here; register 1 write fields are decoded in place
package lif_pkg;

   // Register map, eight byte registers
   localparam logic [2:0] LIF_REG_SEL0      = 3'h0;
   localparam logic [2:0] LIF_REG_CTRL_FLAG = 3'h1;
   localparam logic [2:0] LIF_REG_DATA      = 3'h2;
   localparam logic [2:0] LIF_REG_IRQ_STAT  = 3'h6;
   localparam logic [2:0] LIF_REG_IRQ_MASK  = 3'h7;

   // Register 1 read bit positions
   localparam int LIF_BIT_IFACE_CLEAR_RECEIVED = 4;
   localparam int LIF_BIT_SERVICE_REQUEST_RECEIVED = 3;
   localparam int LIF_BIT_FRAME_AVAILABLE = 2;
   localparam int LIF_BIT_FRAME_MISMATCH = 1;
   localparam int LIF_BIT_OUTPUT_REG_AVAILABLE = 0;

   // Register 0 write bit positions of the self-clearing strobes
   localparam int LIF_BIT_SET_LOCAL_READY  = 2;
   localparam int LIF_BIT_CLEAR_IFACE_CLEAR_FLAG = 1;

   // Reset values
   localparam logic [7:0] LIF_RST_BYTE = 8'h00;
   localparam logic [3:0] LIF_RST_MASK = 4'h0;

   // Self-clear delay of the pulse bits: least 1 us, rounded up
   localparam int LIF_CLK_MHZ      = 40;
   localparam int LIF_SELFCLR_US   = 1;
   localparam int LIF_SELFCLR_CYC  = LIF_SELFCLR_US * LIF_CLK_MHZ;
   // Loop transmit time of one frame in cycles (plain default)
   localparam int LIF_TX_CYC       = 16;

   // Host register port bundle
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } lif_host_req_t;

   // One loop message: three control bits, eight data bits
   typedef struct packed {
      logic [2:0] ctl;
      logic [7:0] data;
   } lif_msg_t;

   // Received frame with its classification
   typedef struct packed {
      lif_msg_t msg;
      logic     is_ifc;
      logic     srq;
      logic     mismatch;
   } lif_rx_t;

   // Transmit engine states
   typedef enum logic [1:0] {
      LIF_TX_IDLE = 2'b01,
      LIF_TX_BUSY = 2'b10
   } lif_tx_state_t;

endpackage

// >>> logic/lif_pulse_timer.sv
// Purpose: Holds a bit high for a fixed number of cycles after a write strobe
// Assumes: Single clock domain
// Notes:   Retriggers on every new strobe
`timescale 1ns/1ps
`default_nettype none
module lif_pulse_timer #(
   parameter int CYCLES = 40
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Control
   input  wire logic start,
   output logic      active
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] count;

   // Down counter, the bit stays up until it runs out
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count <= '0;
      end else if (start) begin
         count <= CW'(CYCLES);
      end else if (count != '0) begin
         count <= count - CW'(1);
      end
   end

   // Registered level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         active <= 1'b0;
      end else begin
         active <= start || (count > CW'(1));
      end
   end
endmodule // lif_pulse_timer
`default_nettype wire

// >>> logic/lif_frame_status.sv
// Purpose: Host-facing message and status registers of a serial loop interface
// Assumes: Host port synchronous to clk; loop receiver delivers one-cycle frame strobes
// Notes:   Registers 6 and 7 hold interrupt status and mask; registers 3 to 5 are scratch
`timescale 1ns/1ps
`default_nettype none
module lif_frame_status
   import lif_pkg::*;
#(
   parameter int TX_CYC = LIF_TX_CYC
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rstn,
   // Host register port
   input  wire lif_host_req_t host_req,
   output logic [7:0]         host_rdata,
   // Loop receive side
   input  wire logic          rx_valid,
   input  wire lif_rx_t       rx_frame,
   // Loop transmit side
   output lif_msg_t           tx_msg,
   output logic               tx_valid,
   output logic               set_local_ready,
   output logic               flag_line_enable,
   // Wake-up and interrupt
   output logic               wake_req,
   output logic               irq
);
   localparam int TW = $clog2(TX_CYC + 1);

   // Flags and holding registers
   logic          iface_clear_received;
   logic          service_request_received;
   logic          frame_available;
   logic          frame_mismatch;
   logic          output_reg_available;
   lif_msg_t      rx_msg;
   lif_msg_t      out_msg;
   logic [7:0]    scratch [0:7];
   logic [3:0]    irq_status;
   logic [3:0]    irq_mask;
   logic          clr_ifc_active;
   lif_tx_state_t tx_state;
   logic [TW-1:0] tx_count;
   logic          out_ctl_pending;

   // Decoded strobes
   logic wr_r0;
   logic wr_r1;
   logic wr_r2;
   logic rd_r2;
   logic clr_ifc_req;
   logic set_local_ready_req;
   logic [3:0] ev_set;

   function automatic logic hit(input lif_host_req_t r, input logic [2:0] a, input logic w);
      hit = (w ? r.wr : r.rd) && (r.addr == a);
   endfunction

   assign wr_r0       = hit(host_req, LIF_REG_SEL0, 1'b1);
   assign wr_r1       = hit(host_req, LIF_REG_CTRL_FLAG, 1'b1);
   assign wr_r2       = hit(host_req, LIF_REG_DATA, 1'b1);
   assign rd_r2       = hit(host_req, LIF_REG_DATA, 1'b0);
   assign clr_ifc_req = wr_r0 && host_req.wdata[LIF_BIT_CLEAR_IFACE_CLEAR_FLAG];
   assign set_local_ready_req   = wr_r0 && host_req.wdata[LIF_BIT_SET_LOCAL_READY];
   // New event bits: ifc, srq, frame available, mismatch
   assign ev_set = {rx_valid && rx_frame.is_ifc,
                    rx_valid && rx_frame.srq && !service_request_received,
                    rx_valid,
                    rx_valid && rx_frame.mismatch};

   // Self-clearing strobe bits
   lif_pulse_timer #(.CYCLES(LIF_SELFCLR_CYC)) u_clr_ifc (
      .clk    (clk),
      .rstn   (rstn),
      .start  (clr_ifc_req),
      .active (clr_ifc_active)
   );
   lif_pulse_timer #(.CYCLES(LIF_SELFCLR_CYC)) u_set_local_ready (
      .clk    (clk),
      .rstn   (rstn),
      .start  (set_local_ready_req),
      .active (set_local_ready)
   );

   // Interface-clear flag; a new ifc frame wins over a clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         iface_clear_received <= 1'b0;
      end else if (rx_valid && rx_frame.is_ifc) begin
         iface_clear_received <= 1'b1;
      end else if (clr_ifc_req) begin
         iface_clear_received <= 1'b0;
      end
   end

   // Service request follows the srq bit of each received message, no host clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         service_request_received <= 1'b0;
      end else if (rx_valid) begin
         service_request_received <= rx_frame.srq;
      end
   end

   // Frame flags; arrival in the read cycle keeps the flag set
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         frame_available <= 1'b0;
         frame_mismatch  <= 1'b0;
      end else begin
         if (rx_valid) begin
            frame_available <= 1'b1;
         end else if (rd_r2) begin
            frame_available <= 1'b0;
         end
         if (rx_valid && rx_frame.mismatch) begin
            frame_mismatch <= 1'b1;
         end else if (rd_r2) begin
            frame_mismatch <= 1'b0;
         end
      end
   end

   // Received message latch
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_msg <= '0;
      end else if (rx_valid) begin
         rx_msg <= rx_frame.msg;
      end
   end

   // Outgoing message: register 1 stores control bits, register 2 write launches
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_msg          <= '0;
         flag_line_enable <= 1'b0;
         out_ctl_pending  <= 1'b0;
      end else begin
         if (wr_r1) begin
            out_msg.ctl      <= host_req.wdata[7:5];
            flag_line_enable <= host_req.wdata[0];
            out_ctl_pending  <= 1'b1;
         end else if (wr_r2) begin
            out_ctl_pending  <= 1'b0;
         end
         if (wr_r2) begin
            out_msg.data <= host_req.wdata;
         end
      end
   end

   // Transmit engine; the host is never stalled, the flag tells it when to wait
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_state             <= LIF_TX_IDLE;
         tx_count             <= '0;
         tx_valid             <= 1'b0;
         tx_msg               <= '0;
         output_reg_available <= 1'b1;
      end else begin
         tx_valid <= 1'b0;
         case (tx_state)
            LIF_TX_IDLE: begin
               if (wr_r2) begin
                  tx_msg               <= '{ctl: out_msg.ctl, data: host_req.wdata};
                  tx_valid             <= 1'b1;
                  tx_count             <= TW'(TX_CYC);
                  output_reg_available <= 1'b0;
                  tx_state             <= LIF_TX_BUSY;
               end
            end
            LIF_TX_BUSY: begin
               if (tx_count <= TW'(1)) begin
                  output_reg_available <= 1'b1;
                  tx_state             <= LIF_TX_IDLE;
               end else begin
                  tx_count <= tx_count - TW'(1);
               end
            end
            default: begin
               tx_state <= LIF_TX_IDLE;
            end
         endcase
      end
   end

   // Scratch bytes for the registers outside this bank
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 8; i++) begin
            scratch[i] <= LIF_RST_BYTE;
         end
      end else if (host_req.wr) begin
         scratch[host_req.addr] <= host_req.wdata;
      end
   end

   // Sticky interrupt status, write one clears, set wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_status <= LIF_RST_MASK;
         irq_mask   <= LIF_RST_MASK;
      end else begin
         if (host_req.wr && host_req.addr == LIF_REG_IRQ_STAT) begin
            irq_status <= (irq_status & ~host_req.wdata[3:0]) | ev_set;
         end else begin
            irq_status <= irq_status | ev_set;
         end
         if (host_req.wr && host_req.addr == LIF_REG_IRQ_MASK) begin
            irq_mask <= host_req.wdata[3:0];
         end
      end
   end

   // Wake-up while any event flag stands; host must clear the cause, except service request, which a message without srq clears
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wake_req <= 1'b0;
         irq      <= 1'b0;
      end else begin
         wake_req <= iface_clear_received || service_request_received
                  || frame_available || frame_mismatch;
         irq      <= |(irq_status & irq_mask);
      end
   end

   // Read mux, data one cycle after the read strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_rdata <= LIF_RST_BYTE;
      end else if (host_req.rd) begin
         case (host_req.addr)
            LIF_REG_SEL0: begin
               host_rdata <= {scratch[0][7:3], 1'b0, clr_ifc_active, scratch[0][0]};
            end
            LIF_REG_CTRL_FLAG: begin
               host_rdata <= {rx_msg.ctl, iface_clear_received, service_request_received,
                              frame_available, frame_mismatch,
                              output_reg_available};
            end
            LIF_REG_DATA: begin
               host_rdata <= rx_msg.data;
            end
            LIF_REG_IRQ_STAT: begin
               host_rdata <= {4'h0, irq_status};
            end
            LIF_REG_IRQ_MASK: begin
               host_rdata <= {4'h0, irq_mask};
            end
            default: begin
               host_rdata <= scratch[host_req.addr];
            end
         endcase
      end else begin
         host_rdata <= LIF_RST_BYTE;
      end
   end

   // Cycles since the last clear strobe, held at a ceiling; a long hold is
   // checked on this count because a deep repetition would be slow to unroll
   localparam int AW = $clog2(LIF_SELFCLR_CYC + 3);
   logic [AW-1:0] clr_age;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clr_age <= '0;
      end else if (clr_ifc_req) begin
         clr_age <= AW'(1);
      end else if (clr_age != '0 && clr_age < AW'(LIF_SELFCLR_CYC + 2)) begin
         clr_age <= clr_age + AW'(1);
      end
   end

   // Checks
   sequence s_rd2;
      host_req.rd && host_req.addr == LIF_REG_DATA && !rx_valid;
   endsequence
   frame_rd_clear_a: assert property (@(posedge clk) disable iff (!rstn)
      s_rd2 |=> !frame_available && !frame_mismatch)
      else $error("frame flags not cleared by data read");
   ifc_set_a: assert property (@(posedge clk) disable iff (!rstn)
      rx_valid && rx_frame.is_ifc |=> iface_clear_received ##1 wake_req)
      else $error("ifc frame did not raise flag and wake");
   ifc_clear_a: assert property (@(posedge clk) disable iff (!rstn)
      clr_ifc_req && !(rx_valid && rx_frame.is_ifc) |=> !iface_clear_received)
      else $error("ifc flag not cleared");
   srq_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      !rx_valid |=> service_request_received == $past(service_request_received))
      else $error("srq flag changed without a message");
   output_reg_available_drop_a: assert property (@(posedge clk) disable iff (!rstn)
      wr_r2 && tx_state == LIF_TX_IDLE |=> !output_reg_available ##TX_CYC output_reg_available)
      else $error("output available timing wrong");
   selfclr_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
      clr_age == AW'(LIF_SELFCLR_CYC + 1) |-> !clr_ifc_active)
      else $error("clear bit did not self reset");
   ctl_read_a: assert property (@(posedge clk) disable iff (!rstn)
      host_req.rd && host_req.addr == LIF_REG_CTRL_FLAG
      |=> host_rdata[LIF_BIT_OUTPUT_REG_AVAILABLE] == $past(output_reg_available)
          && host_rdata[LIF_BIT_IFACE_CLEAR_RECEIVED] == $past(iface_clear_received))
      else $error("register 1 flag bits misplaced");
   data_read_a: assert property (@(posedge clk) disable iff (!rstn)
      host_req.rd && host_req.addr == LIF_REG_DATA |=> host_rdata == $past(rx_msg.data))
      else $error("register 2 read data wrong");
endmodule // lif_frame_status
`default_nettype wire

// >>> tb/lif_loop_model.sv
// Purpose: Far side of the loop: echoes sent frames and delivers injected ones
// Assumes: One outgoing frame in flight at a time
// Notes:   Frame lines toggle while idle so stale data never passes for a frame
`timescale 1ns/1ps
`default_nettype none
module lif_loop_model
   import lif_pkg::*;
#(
   parameter int DLY = 12
) (
   // Clock and reset
   input  wire logic     clk,
   input  wire logic     rstn,
   // From the block
   input  wire lif_msg_t tx_msg,
   input  wire logic     tx_valid,
   // Commands from the bench
   input  wire logic     inj,
   input  wire lif_rx_t  inj_frame,
   input  wire logic     corrupt,
   // To the block
   output lif_rx_t       rx_frame,
   output logic          rx_valid
);
   int       cnt;
   lif_msg_t held;

   // Echo after the loop delay; an injected frame takes the slot and the echo is dropped
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt      <= 0;
         held     <= '0;
         rx_valid <= 1'b0;
         rx_frame <= '0;
      end else begin
         rx_valid <= 1'b0;
         rx_frame <= ~rx_frame; // Idle lines keep changing
         if (tx_valid) begin
            held <= tx_msg;
            cnt  <= DLY;
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end
         if (inj) begin
            rx_valid <= 1'b1;
            rx_frame <= inj_frame;
         end else if (cnt == 1) begin
            rx_valid <= 1'b1;
            rx_frame <= {held, 1'b0, 1'b0, corrupt};
         end
      end
   end
endmodule // lif_loop_model
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Self-checking bench for the loop frame/status register bank
// Assumes: Short transmit time through TX_CYC so the run stays brief
// Notes:   Bench acts as host software; loop model echoes what is sent
`timescale 1ns/1ps
`default_nettype none
module tb;
   import lif_pkg::*;
   typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] e;} lif_row_t;
   localparam int TXC = 4;
   logic          clk;
   logic          rstn;
   logic          rx_valid;
   logic          tx_valid;
   logic          slr;
   logic          fle;
   logic          wake_req;
   logic          irq;
   logic          inj;
   logic          corrupt;
   logic [7:0]    rdata;
   logic [7:0]    d;
   lif_host_req_t req;
   lif_rx_t       rx_frame;
   lif_rx_t       inj_frame;
   lif_msg_t      tx_msg;
   int            n_mismatch;
   int            n_compared;
   int            cyc;
   // Scratch and mask bytes: write, then read back
   lif_row_t rows[6] = '{'{3'h3, 8'h5a, 8'h5a}, '{3'h4, 8'ha5, 8'ha5}, '{3'h5, 8'hff, 8'hff},
                         '{3'h0, 8'hf9, 8'hf9}, '{3'h7, 8'hff, 8'h0f}, '{3'h7, 8'h00, 8'h00}};

   lif_frame_status #(.TX_CYC(TXC)) lif_frame_status_i (.clk(clk), .rstn(rstn),
      .host_req(req), .host_rdata(rdata), .rx_valid(rx_valid), .rx_frame(rx_frame),
      .tx_msg(tx_msg), .tx_valid(tx_valid), .set_local_ready(slr),
      .flag_line_enable(fle), .wake_req(wake_req), .irq(irq));
   lif_loop_model lif_loop_model_i (.clk(clk), .rstn(rstn), .tx_msg(tx_msg),
      .tx_valid(tx_valid), .inj(inj), .inj_frame(inj_frame), .corrupt(corrupt),
      .rx_frame(rx_frame), .rx_valid(rx_valid));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Frame from the loop, then time for flags and wake-up to settle
   task automatic send(input lif_rx_t f);
      @(posedge clk);
      inj <= 1'b1;
      inj_frame <= f;
      @(posedge clk);
      inj <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic finish_test;
      $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Clock, 25 ns period
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         finish_test();
      end
   end

   initial begin
      rstn = 1'b0;
      req = '0;
      inj = 1'b0;
      inj_frame = '0;
      corrupt = 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rd(LIF_REG_CTRL_FLAG, d); chk(d, 8'h01);
      rd(LIF_REG_IRQ_STAT, d); chk(d, LIF_RST_BYTE);
      chk({7'h0, wake_req}, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, d); chk(d, rows[i].e);
      end
      // Interface clear: flag, wake-up, host clear, self-dropping bits
      send({3'h4, 8'h00, 1'b1, 1'b0, 1'b0});
      rd(LIF_REG_CTRL_FLAG, d); chk(d & 8'h10, 8'h10);
      chk({7'h0, wake_req}, 8'h01);
      wr(LIF_REG_SEL0, 8'h02);
      rd(LIF_REG_CTRL_FLAG, d); chk(d & 8'h10, 8'h00);
      repeat (45) @(posedge clk);
      rd(LIF_REG_SEL0, d); chk(d & 8'h06, 8'h00);
      wr(LIF_REG_SEL0, 8'h04);
      repeat (2) @(posedge clk);
      #1 chk({7'h0, slr}, 8'h01);
      repeat (45) @(posedge clk);
      #1 chk({7'h0, slr}, 8'h00);
      // Service request survives host writes, clears on a plain data frame
      send({3'h4, 8'h00, 1'b0, 1'b1, 1'b0});
      rd(LIF_REG_CTRL_FLAG, d); chk(d & 8'h08, 8'h08);
      wr(LIF_REG_SEL0, 8'h02);
      wr(LIF_REG_CTRL_FLAG, 8'h00);
      rd(LIF_REG_CTRL_FLAG, d); chk(d & 8'h08, 8'h08);
      send({3'h0, 8'h3c, 1'b0, 1'b0, 1'b0});
      rd(LIF_REG_CTRL_FLAG, d); chk(d & 8'hec, 8'h04);
      rd(LIF_REG_DATA, d); chk(d, 8'h3c);
      rd(LIF_REG_CTRL_FLAG, d); chk(d & 8'h06, 8'h00);
      send({3'h7, 8'hc3, 1'b0, 1'b0, 1'b1});
      rd(LIF_REG_CTRL_FLAG, d); chk(d & 8'he2, 8'he2);
      rd(LIF_REG_DATA, d); chk(d, 8'hc3);
      rd(LIF_REG_CTRL_FLAG, d); chk(d & 8'h06, 8'h00);
      chk({7'h0, wake_req}, 8'h00);
      // Sticky status stays masked until the mask opens
      chk({7'h0, irq}, 8'h00);
      rd(LIF_REG_IRQ_STAT, d); chk(d, 8'h0f);
      wr(LIF_REG_IRQ_MASK, 8'h02);
      @(posedge clk);
      #1 chk({7'h0, irq}, 8'h01);
      wr(LIF_REG_IRQ_STAT, 8'h0f);
      @(posedge clk);
      #1 chk({7'h0, irq}, 8'h00);
      rd(LIF_REG_IRQ_STAT, d); chk(d, 8'h00);
      // Outgoing message: host checks flags, sends, a second write while busy is dropped
      rd(LIF_REG_CTRL_FLAG, d); chk(d & 8'h03, 8'h01);
      wr(LIF_REG_CTRL_FLAG, 8'hc0);
      wr(LIF_REG_DATA, 8'h81);
      #1 chk({7'h0, tx_valid}, 8'h01);
      chk(tx_msg.data, 8'h81);
      chk({5'h0, tx_msg.ctl}, 8'h06);
      wr(LIF_REG_DATA, 8'h18);
      #1 chk({7'h0, tx_valid}, 8'h00);
      for (int k = 0; k < 20; k++) begin
         rd(LIF_REG_CTRL_FLAG, d);
         if (d[LIF_BIT_OUTPUT_REG_AVAILABLE] === 1'b1) break;
      end
      chk(d & 8'h01, 8'h01);
      chk({7'h0, fle}, 8'h00);
      repeat (20) @(posedge clk);
      rd(LIF_REG_CTRL_FLAG, d); chk(d & 8'he6, 8'hc4);
      rd(LIF_REG_DATA, d); chk(d, 8'h81);
      // Reset in mid-run restores the idle picture
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(LIF_REG_CTRL_FLAG, d); chk(d, 8'h01);
      rd(LIF_REG_IRQ_MASK, d); chk(d, LIF_RST_BYTE);
      finish_test();
   end
endmodule // tb
`default_nettype wire
